// ===== verilog/lce_params.svh
// Constants of the display command executor.
// Operation
// RULE1 - Pointer-load command (bit 6 low) copies bits 5..0 into the pointer.
// RULE2 - Subaddress command (bits 6..3 = 1100) loads the subaddress counter.
// RULE3 - Bank-select bit 1 picks the storage bank in static and 1:2 modes.
// RULE4 - Bank-select bit 0 picks the bank that drives the display.
// RULE5 - Bank-select is ignored in 1:3 and 1:4 drive modes.
// RULE6 - Blink-select bit 2 chooses normal or alternate-bank blinking.
// RULE7 - In 1:3 and 1:4 modes blinking is always normal.
// RULE8 - Blink-select bits 1..0 give the blink rate, 00 meaning off.
// RULE9 - Executed commands are held in status registers driving the display.
// RULE10 - Display data fill RAM in the order set by drive mode and bank.
// RULE11 - Bit 7 set means another command follows, clear means data follow.
// RULE12 - Drive code 01 static, 10 1:2, 11 1:3, 00 1:4.
// RULE13 - Pointer and subaddress counter advance after each stored RAM word; the code steps the subaddress only when the pointer wraps past 39.
// RULE14 - The master loads only pointer values 0 to 39.
`ifndef LCE_PARAMS_SVH
`define LCE_PARAMS_SVH
`define LCE_CONT_BIT 7
`define LCE_PTR_LAST 6'h27
`define LCE_PTR_RST 6'h00
`define LCE_SUB_RST 3'h0
`define LCE_OP_DEVSEL 4'hC
`define LCE_OP_BANK 5'h1E
`define LCE_OP_BLINK 4'hE
`define LCE_OP_MODE 2'h2
`define LCE_DRV_STATIC 2'h1
`define LCE_DRV_MUX2 2'h2
`define LCE_DRV_MUX3 2'h3
`define LCE_DRV_MUX4 2'h0
`define LCE_DRV_RST 2'h0
`define LCE_RATE_RST 2'h0
`define LCE_BYTE_BITS 4'h8
`define LCE_HI_BANK 2'h2
`endif

// ===== verilog/lce_pkg.sv
// Types shared by the display command executor.
package lce_pkg;
	typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_FILL = 1'b1} lce_state_t;
	typedef struct packed {
		logic dispEnable;
		logic halfBias;
		logic [1:0] driveMode;
		logic inBank;
		logic outBank;
		logic blinkAlt;
		logic [1:0] blink_rate_sel;
	} lce_status_t;
endpackage : lce_pkg

// ===== verilog/lce_command_executor.sv
// Command decoder, status registers and display RAM filling.
`timescale 1ns/1ns
`include "lce_params.svh"
module lce_command_executor (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic nrst,
	// Received bytes from the bus slave.
	input wire logic xferStart,
	input wire logic byteValid,
	input wire logic [7:0] byteData,
	output logic byteReady,
	// Hardware subaddress strap.
	input wire logic [2:0] hwSubaddr,
	// Display retrieval port.
	input wire logic [5:0] dispAddr,
	output logic [3:0] dispBits,
	// State seen by the outside.
	output lce_pkg::lce_status_t status,
	output logic [5:0] dataPtr,
	output logic [2:0] subCount,
	output logic cmdPhase,
	output logic devSelected
);

	// ==========================================================
	// Storage.
	lce_pkg::lce_state_t state_reg, state_next;
	lce_pkg::lce_status_t stat_reg, stat_next;
	logic [5:0] ptr_reg, ptr_next;
	logic [2:0] sub_reg, sub_next;
	logic cmd_reg, cmd_next;
	logic ready_reg, ready_next;
	logic [7:0] shift_reg, shift_next;
	logic [3:0] left_reg, left_next;
	logic [3:0] disp_reg;
	logic sel_reg;
	logic [3:0] ramMem [0:39];

	// ==========================================================
	// Functions.
	function automatic logic mux34(input logic [1:0] m);
		mux34 = (m == `LCE_DRV_MUX3) || (m == `LCE_DRV_MUX4);
	endfunction : mux34

	function automatic logic [3:0] stepBits(input logic [1:0] m);
		case (m)
			`LCE_DRV_STATIC: stepBits = 4'h1;
			`LCE_DRV_MUX2: stepBits = 4'h2;
			`LCE_DRV_MUX3: stepBits = 4'h3;
			default: stepBits = 4'h4;
		endcase
	endfunction : stepBits

	// Bits are taken MSB first; the first bit goes to the lowest row.
	function automatic logic [3:0] fillWord(input logic [3:0] old,
		input logic [7:0] sh, input logic [3:0] n, input logic [3:0] lft,
		input logic [1:0] base);
		logic [3:0] w;
		w = old;
		for (int i = 0; i < 4; i++)
		begin
			if (4'(i) < n && 4'(i) < lft)
				w[2'(i) + base] = sh[7 - i];
		end
		fillWord = w;
	endfunction : fillWord

	// ==========================================================
	// Command decoding.
	wire take = byteValid & ready_reg;
	wire isCmd = take & cmd_reg;
	wire isData = take & ~cmd_reg;
	wire opPtr = ~byteData[6];
	wire opSub = byteData[6:3] == `LCE_OP_DEVSEL;
	wire opBank = byteData[6:2] == `LCE_OP_BANK;
	wire opBlink = byteData[6:3] == `LCE_OP_BLINK;
	wire opMode = byteData[6:5] == `LCE_OP_MODE;
	wire curMux34 = mux34(stat_reg.driveMode);
	wire [3:0] nStep = stepBits(stat_reg.driveMode);
	wire [1:0] inBase = (!curMux34 && stat_reg.inBank) ?
		`LCE_HI_BANK : 2'h0;
	wire ptrValid = ptr_reg <= `LCE_PTR_LAST;
	wire doWrite = (state_reg == lce_pkg::ST_FILL) &&
		(sub_reg == hwSubaddr) && ptrValid;
	wire [3:0] ramOld = ptrValid ? ramMem[ptr_reg] : 4'h0;
	wire [3:0] ramNew = fillWord(ramOld, shift_reg, nStep, left_reg,
		inBase);
	wire lastStep = left_reg <= nStep;
	wire ptrWrap = ptr_reg >= `LCE_PTR_LAST;
	wire [3:0] dispRaw = (dispAddr <= `LCE_PTR_LAST) ?
		ramMem[dispAddr] : 4'h0;
	wire outHi = stat_reg.outBank;

	// ==========================================================
	// Next status.
	always_comb
	begin
		stat_next = stat_reg;
		if (isCmd && !opPtr && !opSub && opBank &&
			!curMux34) // [RULE5] [RULE9]
		begin
			stat_next.inBank = byteData[1]; // [RULE3]
			stat_next.outBank = byteData[0]; // [RULE4]
		end
		else if (isCmd && !opPtr && !opSub && opBlink)
		begin
			stat_next.blinkAlt = byteData[2] & ~curMux34; // [RULE6] [RULE7]
			stat_next.blink_rate_sel = byteData[1:0]; // [RULE8]
		end
		else if (isCmd && !opPtr && opMode)
		begin
			stat_next.dispEnable = byteData[3];
			stat_next.halfBias = byteData[2];
			stat_next.driveMode = byteData[1:0]; // [RULE12]
			if (mux34(byteData[1:0]))
				stat_next.blinkAlt = 1'b0; // [RULE7]
		end
	end

	// ==========================================================
	// Pointer, subaddress and fill sequence.
	always_comb
	begin
		state_next = state_reg;
		ptr_next = ptr_reg;
		sub_next = sub_reg;
		cmd_next = cmd_reg;
		ready_next = ready_reg;
		shift_next = shift_reg;
		left_next = left_reg;
		if (xferStart)
			cmd_next = 1'b1;
		else if (isCmd)
			cmd_next = byteData[`LCE_CONT_BIT]; // [RULE11]
		if (isCmd && opPtr)
			ptr_next = byteData[5:0]; // [RULE1]
		else if (isCmd && opSub)
			sub_next = byteData[2:0]; // [RULE2]
		case (state_reg)
			lce_pkg::ST_IDLE:
			begin
				if (isData)
				begin
					state_next = lce_pkg::ST_FILL;
					shift_next = byteData;
					left_next = `LCE_BYTE_BITS;
					ready_next = 1'b0;
				end
			end
			lce_pkg::ST_FILL:
			begin
				shift_next = shift_reg << nStep; // [RULE10]
				left_next = lastStep ? 4'h0 : left_reg - nStep;
				ptr_next = ptrWrap ? `LCE_PTR_RST : ptr_reg + 6'h01; // [RULE13]
				if (ptrWrap)
					sub_next = sub_reg + 3'h1; // [RULE13]
				if (lastStep)
				begin
					state_next = lce_pkg::ST_IDLE;
					ready_next = 1'b1;
				end
			end
			default:
			begin
				state_next = lce_pkg::ST_IDLE;
				ready_next = 1'b1;
			end
		endcase
	end

	// ==========================================================
	// Registers.
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg <= lce_pkg::ST_IDLE;
			stat_reg <= '{dispEnable: 1'b0, halfBias: 1'b0,
				driveMode: `LCE_DRV_RST, inBank: 1'b0, outBank: 1'b0,
				blinkAlt: 1'b0, blink_rate_sel: `LCE_RATE_RST};
			ptr_reg <= `LCE_PTR_RST;
			sub_reg <= `LCE_SUB_RST;
			cmd_reg <= 1'b1;
			ready_reg <= 1'b1;
			shift_reg <= 8'h00;
			left_reg <= 4'h0;
		end
		else
		begin
			state_reg <= state_next;
			stat_reg <= stat_next;
			ptr_reg <= ptr_next;
			sub_reg <= sub_next;
			cmd_reg <= cmd_next;
			ready_reg <= ready_next;
			shift_reg <= shift_next;
			left_reg <= left_next;
		end
	end

	// The RAM has no reset; software is expected to fill it first.
	always_ff @(posedge clk_sys)
	begin
		if (doWrite)
			ramMem[ptr_reg[5:0]] <= ramNew; // [RULE10] [RULE14]
	end

	// Retrieval picks the output bank in static and 1:2 modes only.
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			disp_reg <= 4'h0;
			sel_reg <= 1'b0;
		end
		else
		begin
			if (curMux34)
				disp_reg <= dispRaw;
			else if (stat_reg.driveMode == `LCE_DRV_STATIC)
				disp_reg <= {3'h0, outHi ? dispRaw[2] : dispRaw[0]}; // [RULE4]
			else
				disp_reg <= {2'h0, outHi ? dispRaw[3:2] : dispRaw[1:0]};
			sel_reg <= sub_next == hwSubaddr;
		end
	end

	assign byteReady = ready_reg;
	assign dispBits = disp_reg;
	assign status = stat_reg;
	assign dataPtr = ptr_reg;
	assign subCount = sub_reg;
	assign cmdPhase = cmd_reg;
	assign devSelected = sel_reg;

	// ==========================================================
	// Assertions.
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	a_ptr_load: assert property (isCmd && opPtr |=> // [RULE1]
		ptr_reg == $past(byteData[5:0]))
		else $error("Pointer not loaded.");
	a_sub_load: assert property (isCmd && opSub |=> // [RULE2]
		sub_reg == $past(byteData[2:0]))
		else $error("Subaddress not loaded.");
	a_bank_load: assert property (isCmd && opBank && !curMux34 |=> // [RULE3]
		stat_reg.inBank == $past(byteData[1]) &&
		stat_reg.outBank == $past(byteData[0]))
		else $error("Bank select not taken.");
	a_bank_ignore: assert property (isCmd && opBank && curMux34 |=> // [RULE5]
		$stable(stat_reg.inBank) && $stable(stat_reg.outBank))
		else $error("Bank select not ignored.");
	a_blink_load: assert property (isCmd && opBlink |=> // [RULE8]
		stat_reg.blink_rate_sel == $past(byteData[1:0]))
		else $error("Blink rate not loaded.");
	a_blink_mode: assert property (isCmd && opBlink && !curMux34 |=> // [RULE6]
		stat_reg.blinkAlt == $past(byteData[2]))
		else $error("Blink mode not loaded.");
	a_blink_normal: assert property (curMux34 |-> // [RULE7]
		!stat_reg.blinkAlt)
		else $error("Alternate blink in 1:3 or 1:4.");
	a_cont_flag: assert property (isCmd && !xferStart |=> // [RULE11]
		cmd_reg == $past(byteData[7]))
		else $error("Continuation flag misread.");
	a_mode_load: assert property (isCmd && opMode && !opPtr |=> // [RULE12]
		stat_reg.driveMode == $past(byteData[1:0]))
		else $error("Drive mode not loaded.");
	a_ptr_step: assert property (state_reg == lce_pkg::ST_FILL &&
		!ptrWrap |=> ptr_reg == $past(ptr_reg) + 6'h01) // [RULE13]
		else $error("Pointer did not advance.");
	a_fill_len: assert property (isData && // [RULE10]
		stat_reg.driveMode == `LCE_DRV_MUX4 |=>
		(state_reg == lce_pkg::ST_FILL) [*2] ##1
		state_reg == lce_pkg::ST_IDLE)
		else $error("1:4 fill length wrong.");
	a_status_held: assert property (!isCmd |=> $stable(stat_reg)) // [RULE9]
		else $error("Status changed without command.");

	c_static_fill: cover property (isData &&
		stat_reg.driveMode == `LCE_DRV_STATIC);
	c_ptr_wrap: cover property (state_reg == lce_pkg::ST_FILL && ptrWrap);
	c_bank_ignored: cover property (isCmd && opBank && curMux34);
	c_last_cmd: cover property (isCmd && !byteData[7]);

endmodule : lce_command_executor

// ===== sim/lce_master_model.sv
// Bus master model that offers command and data bytes to the executor.
`timescale 1ns/1ns
module lce_master_model (
	// Clock.
	input wire logic clk_sys,
	// Byte port.
	input wire logic byteReady,
	output logic xferStart,
	output logic byteValid,
	output logic [7:0] byteData
);
	// ======================================================
	// Byte driver
	initial
	begin
		xferStart = 1'b0;
		byteValid = 1'b0;
		byteData = 8'h00;
	end
	task start;
	begin
		@(negedge clk_sys);
		xferStart = 1'b1;
		@(negedge clk_sys);
		xferStart = 1'b0;
	end
	endtask : start
	// The byte stands until the edge that takes it.
	task put(input logic [7:0] b);
	begin
		@(negedge clk_sys);
		byteValid = 1'b1;
		byteData = b;
		while (byteReady !== 1'b1)
			@(negedge clk_sys);
		@(posedge clk_sys);
	end
	endtask : put
	// A released data line shows the inverse, never a stale copy.
	task idle;
	begin
		@(negedge clk_sys);
		byteValid = 1'b0;
		byteData = ~byteData;
	end
	endtask : idle
endmodule : lce_master_model

// ===== sim/tb_lce_command_executor.sv
// Testbench of the display command executor.
`timescale 1ns/1ns
module tb_lce_command_executor;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic xferStart, byteValid, byteReady, cmdPhase, devSelected;
	logic [7:0] byteData;
	logic [2:0] hwSubaddr;
	logic [2:0] subCount;
	logic [5:0] dispAddr;
	logic [5:0] dataPtr;
	logic [3:0] dispBits;
	lce_pkg::lce_status_t status;
	int failures = 0;
	int checked = 0;
	always #10 clk_sys = ~clk_sys;
	lce_master_model mst (.clk_sys(clk_sys), .byteReady(byteReady),
		.xferStart(xferStart), .byteValid(byteValid),
		.byteData(byteData));
	lce_command_executor uut (.clk_sys(clk_sys), .nrst(nrst),
		.xferStart(xferStart), .byteValid(byteValid),
		.byteData(byteData), .byteReady(byteReady),
		.hwSubaddr(hwSubaddr), .dispAddr(dispAddr),
		.dispBits(dispBits), .status(status), .dataPtr(dataPtr),
		.subCount(subCount), .cmdPhase(cmdPhase),
		.devSelected(devSelected));
	// ======================================================
	// Helpers
	task chk(input string what, input logic [8:0] e, input logic [8:0] g);
	begin
		checked++;
		if (g !== e)
		begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, e, g);
		end
	end
	endtask : chk
	// Lets the edge after the last take land before looking.
	task rest;
	begin
		mst.idle();
		@(negedge clk_sys);
	end
	endtask : rest
	task tally_and_finish;
	begin
		if (failures == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask : tally_and_finish
	// ======================================================
	// Scenarios
	task t_reset;
	begin
		chk("status", 9'h000, status);
		chk("ptr", 9'h000, dataPtr);
		chk("phase", 9'h001, cmdPhase);
		chk("ready", 9'h001, byteReady);
		chk("sub", 9'h000, subCount);
		chk("disp", 9'h000, dispBits);
		chk("sel", 9'h000, devSelected);
	end
	endtask : t_reset
	task t_cmds;
	begin
		mst.start();
		mst.put(8'hA7);
		mst.put(8'hE5);
		mst.put(8'h42);
		rest();
		chk("ptr", 9'h027, dataPtr);
		chk("sub", 9'h005, subCount);
		chk("mode", 9'h002, status.driveMode);
		chk("phase", 9'h000, cmdPhase);
	end
	endtask : t_cmds
	task t_bank;
	begin
		mst.start();
		mst.put(8'hC9);
		mst.put(8'hFA);
		rest();
		chk("inBank", 9'h001, status.inBank);
		chk("outBank", 9'h000, status.outBank);
		mst.put(8'hC8);
		mst.put(8'hF9);
		mst.put(8'hF6);
		rest();
		chk("inBank", 9'h001, status.inBank);
		chk("outBank", 9'h000, status.outBank);
		chk("alt", 9'h000, status.blinkAlt);
		chk("rate", 9'h002, status.blink_rate_sel);
	end
	endtask : t_bank
	task t_blink;
	begin
		mst.start();
		mst.put(8'hC9);
		for (int r = 0; r < 4; r++)
		begin
			mst.put(8'hF4 | 8'(r));
			rest();
			chk("rate", 9'(r), status.blink_rate_sel);
			chk("alt", 9'h001, status.blinkAlt);
		end
		chk("enable", 9'h001, status.dispEnable);
	end
	endtask : t_blink
	// Two bytes in 1:4 mode; the second goes to another subaddress.
	task t_fill;
	begin
		mst.start();
		mst.put(8'hC8);
		mst.put(8'hE0);
		mst.put(8'h26);
		mst.put(8'hA5);
		mst.put(8'h3C);
		rest();
		repeat (4) @(negedge clk_sys);
		chk("ptr", 9'h002, dataPtr);
		chk("sub", 9'h001, subCount);
		chk("sel", 9'h000, devSelected);
		dispAddr = 6'h26;
		repeat (2) @(negedge clk_sys);
		chk("word38", 9'h005, dispBits);
		dispAddr = 6'h27;
		repeat (2) @(negedge clk_sys);
		chk("word39", 9'h00A, dispBits);
	end
	endtask : t_fill
	// Static fill into the upper bank, then 1:2 fill, on subaddress 1.
	// Only the bank bits that were written are ever shown, since the RAM
	// holds no defined value until it is filled.
	task t_banks;
	begin
		hwSubaddr = 3'h1;
		mst.start();
		mst.put(8'hC9);
		mst.put(8'hE1);
		mst.put(8'hFB);
		mst.put(8'h00);
		mst.put(8'h80);
		rest();
		repeat (10) @(negedge clk_sys);
		chk("ptr", 9'h008, dataPtr);
		chk("sel", 9'h001, devSelected);
		dispAddr = 6'h00;
		repeat (2) @(negedge clk_sys);
		chk("word0", 9'h001, dispBits);
		dispAddr = 6'h01;
		repeat (2) @(negedge clk_sys);
		chk("word1", 9'h000, dispBits);
		mst.start();
		mst.put(8'hCA);
		mst.put(8'hF8);
		mst.put(8'hF5);
		mst.put(8'h10);
		mst.put(8'hB4);
		rest();
		repeat (6) @(negedge clk_sys);
		chk("ptr", 9'h014, dataPtr);
		chk("alt", 9'h001, status.blinkAlt);
		dispAddr = 6'h11;
		repeat (2) @(negedge clk_sys);
		chk("word17", 9'h003, dispBits);
		dispAddr = 6'h12;
		repeat (2) @(negedge clk_sys);
		chk("word18", 9'h002, dispBits);
		mst.start();
		mst.put(8'h4B);
		rest();
		chk("mode", 9'h003, status.driveMode);
		chk("alt", 9'h000, status.blinkAlt);
	end
	endtask : t_banks
	// A reset in the middle of a fill must bring every register back.
	task t_midreset;
	begin
		mst.start();
		mst.put(8'h05);
		mst.put(8'hFF);
		@(negedge clk_sys);
		nrst = 1'b0;
		mst.idle();
		@(negedge clk_sys);
		nrst = 1'b1;
		t_reset();
	end
	endtask : t_midreset
	// ======================================================
	// Sequence and watchdog
	initial
	begin
		hwSubaddr = 3'h0;
		dispAddr = 6'h00;
		repeat (20) @(negedge clk_sys);
		nrst = 1'b1;
		t_reset();
		t_cmds();
		t_bank();
		t_blink();
		t_fill();
		t_banks();
		t_midreset();
		tally_and_finish();
	end
	// The whole run needs about 126 cycles; this allows about sixteen times that.
	initial
	begin
		#40000;
		failures++;
		tally_and_finish();
	end
endmodule : tb_lce_command_executor
